// ==== logic/mpc_pwm_out.sv ====
// The register addresses and register access over APB were decided locally.
module mpc_pwm_out (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer side
  input wire logic update_event,
  input wire logic [mpc_pkg::NCH-1:0] ref_in,
  // Pins
  input wire logic break_pin,
  input wire logic trigger_input,
  input wire logic ext_trigger_filtered,
  output logic [mpc_pkg::NCH-1:0] channel_out,
  output logic [mpc_pkg::NCH-1:0] channel_out_oe,
  output logic [mpc_pkg::NCH-1:0] channel_out_compl,
  output logic [mpc_pkg::NCH-1:0] channel_out_compl_oe,
  // Interrupt requests
  output logic irq_commutation,
  output logic irq_break
);
  localparam int N = mpc_pkg::NCH;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic break_enable_reg, break_polarity_reg, auto_output_reenable_reg;
  logic offstate_idle_select_reg, offstate_run_select_reg;
  logic [1:0] lock_reg;
  logic lock_done_reg;
  logic main_output_enable_reg;
  logic commutation_flag_reg, break_flag_reg;
  logic commutation_irq_enable_reg, break_irq_enable_reg;
  logic [7:0] dt_reg;
  mpc_pkg::mpc_cfg_s pre_reg [N];
  mpc_pkg::mpc_cfg_s act_reg [N];
  mpc_pkg::mpc_ctl_s ctl_reg [N];
  logic [N-1:0] clr_reg, refq_reg;
  logic [7:0] dtc_reg [N];
  logic brk_s1_reg, brk_s2_reg;
  logic outen_s1_reg, outen_s2_reg, outen_s3_reg;
  logic trg_s1_reg, trg_s2_reg, trg_s3_reg;
  logic etr_s1_reg, etr_s2_reg;
  logic [7:0] bkc_reg;
  logic [31:0] prdata_reg;

  // Bus decode
  logic wr, setup, wr_ctrl, wr_stat, hit;
  logic brk_async, comm_ev, outen_fall, idle_ready;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign wr_ctrl = wr & (paddr == mpc_pkg::OFF_CTRL);
  assign wr_stat = wr & (paddr == mpc_pkg::OFF_STAT);
  assign hit = (paddr <= mpc_pkg::OFF_CH0 + mpc_pkg::CH_STRIDE * 8'(N - 1)) & (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // Break path
  // ---------------------------------------------------------------
  // enable and polarity select
  assign brk_async = break_enable_reg & (break_pin == break_polarity_reg);

  // Break level into clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_s1_reg <= 1'b0;
      brk_s2_reg <= 1'b0;
    end else begin
      brk_s1_reg <= brk_async;
      brk_s2_reg <= brk_s1_reg;
    end
  end

  // Main output enable, cleared without clock on break
  // asynchronous break clear
  always_ff @(posedge pclk or negedge presetn or posedge brk_async) begin
    if (!presetn) begin
      main_output_enable_reg <= 1'b0;
    end else if (brk_async) begin
      main_output_enable_reg <= 1'b0;
    end else if (!brk_s2_reg) begin
      if (wr_ctrl) begin
        main_output_enable_reg <= pwdata[mpc_pkg::B_MAIN_EN];
      end else if (update_event && auto_output_reenable_reg) begin
        main_output_enable_reg <= 1'b1;
      end
    end else if (wr_ctrl && !pwdata[mpc_pkg::B_MAIN_EN]) begin
      main_output_enable_reg <= 1'b0;
    end
  end

  // Enable resynchroniser and fall detect
  // synchronous view of enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outen_s1_reg <= 1'b0;
      outen_s2_reg <= 1'b0;
      outen_s3_reg <= 1'b0;
    end else begin
      outen_s1_reg <= main_output_enable_reg;
      outen_s2_reg <= outen_s1_reg;
      outen_s3_reg <= outen_s2_reg;
    end
  end
  assign outen_fall = outen_s3_reg & ~outen_s2_reg;

  // Dead time after break, counted from synchronised fall
  // resync adds two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bkc_reg <= mpc_pkg::DT_RST;
    end else if (outen_fall) begin
      bkc_reg <= dt_reg;
    end else if (bkc_reg != 8'h00) begin
      bkc_reg <= bkc_reg - 8'h01;
    end
  end
  assign idle_ready = ~main_output_enable_reg & ~outen_s2_reg & ~outen_fall & (bkc_reg == 8'h00);

  // ---------------------------------------------------------------
  // Control register and lock
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_enable_reg <= 1'b0;
      break_polarity_reg <= 1'b0;
      auto_output_reenable_reg <= 1'b0;
      offstate_idle_select_reg <= 1'b0;
      offstate_run_select_reg <= 1'b0;
      lock_reg <= 2'h0;
      lock_done_reg <= 1'b0;
    end else if (wr_ctrl) begin
      auto_output_reenable_reg <= pwdata[mpc_pkg::B_AUTO_EN];
      lock_done_reg <= 1'b1;
      if (!lock_done_reg) begin
        lock_reg <= pwdata[mpc_pkg::B_LOCK +: 2];
      end
      if (lock_reg < mpc_pkg::LOCK_L1) begin
        break_enable_reg <= pwdata[mpc_pkg::B_BRK_EN];
        break_polarity_reg <= pwdata[mpc_pkg::B_BRK_POL];
      end
      if (lock_reg < mpc_pkg::LOCK_L2) begin
        offstate_idle_select_reg <= pwdata[mpc_pkg::B_OFF_IDLE];
        offstate_run_select_reg <= pwdata[mpc_pkg::B_OFF_RUN];
      end
    end
  end

  // Commutation trigger sync and event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s1_reg <= 1'b0;
      trg_s2_reg <= 1'b0;
      trg_s3_reg <= 1'b0;
      etr_s1_reg <= 1'b0;
      etr_s2_reg <= 1'b0;
    end else begin
      trg_s1_reg <= trigger_input;
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
      etr_s1_reg <= ext_trigger_filtered;
      etr_s2_reg <= etr_s1_reg;
    end
  end
  assign comm_ev = (wr & (paddr == mpc_pkg::OFF_EVT) & pwdata[mpc_pkg::B_COMM_SW]) | (trg_s2_reg & ~trg_s3_reg);

  // Status flags, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_flag_reg <= 1'b0;
      break_flag_reg <= 1'b0;
    end else begin
      if (comm_ev) begin
        commutation_flag_reg <= 1'b1;
      end else if (wr_stat && !pwdata[mpc_pkg::B_COMF]) begin
        commutation_flag_reg <= 1'b0;
      end
      // break flag, no clear during break
      if (brk_s2_reg) begin
        break_flag_reg <= 1'b1;
      end else if (wr_stat && !pwdata[mpc_pkg::B_BRKF]) begin
        break_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt enables and dead time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_irq_enable_reg <= 1'b0;
      break_irq_enable_reg <= 1'b0;
      dt_reg <= mpc_pkg::DT_RST;
    end else begin
      if (wr && paddr == mpc_pkg::OFF_IEN) begin
        commutation_irq_enable_reg <= pwdata[mpc_pkg::B_COMF];
        break_irq_enable_reg <= pwdata[mpc_pkg::B_BRKF];
      end
      if (wr && paddr == mpc_pkg::OFF_DT) begin
        dt_reg <= pwdata[7:0];
      end
    end
  end
  assign irq_commutation = commutation_flag_reg & commutation_irq_enable_reg;
  assign irq_break = break_flag_reg & break_irq_enable_reg;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  logic [31:0] ch_rd [N];
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic wr_ch, forced, ref_eff, dz, both_idle_act;
    assign wr_ch = wr & (paddr == mpc_pkg::OFF_CH0 + mpc_pkg::CH_STRIDE * 8'(i));
    assign forced = (act_reg[i].mode == mpc_pkg::MODE_FORCE_LO) | (act_reg[i].mode == mpc_pkg::MODE_FORCE_HI);
    assign ref_eff = forced ? act_reg[i].mode[0] : (ref_in[i] & ~clr_reg[i]);
    assign dz = (dtc_reg[i] == 8'h00);
    assign both_idle_act = (ctl_reg[i].idle_m != ctl_reg[i].pol_m) & (ctl_reg[i].idle_c != ctl_reg[i].pol_c);
    assign ch_rd[i] = {11'h0, act_reg[i], 6'h0, ctl_reg[i], pre_reg[i]};

    // Preload, static settings and commutation copy
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_reg[i] <= '0;
        act_reg[i] <= '0;
        ctl_reg[i] <= '0;
      end else begin
        if (wr_ch) begin
          pre_reg[i].men <= pwdata[3];
          pre_reg[i].cen <= pwdata[4];
          if (lock_reg < mpc_pkg::LOCK_L3) begin
            pre_reg[i].mode <= pwdata[2:0];
          end
          ctl_reg[i].rce <= pwdata[mpc_pkg::CH_CTRL_LSB];
          if (lock_reg < mpc_pkg::LOCK_L2) begin
            ctl_reg[i].pol_m <= pwdata[mpc_pkg::CH_CTRL_LSB + 1];
            ctl_reg[i].pol_c <= pwdata[mpc_pkg::CH_CTRL_LSB + 2];
          end
          if (lock_reg < mpc_pkg::LOCK_L1) begin
            ctl_reg[i].idle_m <= pwdata[mpc_pkg::CH_CTRL_LSB + 3];
            ctl_reg[i].idle_c <= pwdata[mpc_pkg::CH_CTRL_LSB + 4];
          end
        end
        if (comm_ev) begin
          act_reg[i] <= wr_ch ? mpc_pkg::mpc_cfg_s'(pwdata[4:0]) : pre_reg[i];
        end
      end
    end

    // Reference clear latch and dead-time counter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        clr_reg[i] <= 1'b0;
        refq_reg[i] <= 1'b0;
        dtc_reg[i] <= mpc_pkg::DT_RST;
      end else begin
        if (ctl_reg[i].rce && etr_s2_reg) begin
          clr_reg[i] <= 1'b1;
        end else if (update_event) begin
          clr_reg[i] <= 1'b0;
        end
        refq_reg[i] <= ref_eff;
        if (ref_eff != refq_reg[i]) begin
          dtc_reg[i] <= dt_reg;
        end else if (!dz) begin
          dtc_reg[i] <= dtc_reg[i] - 8'h01;
        end
      end
    end

    // Output selection
    always_comb begin
      channel_out[i] = ctl_reg[i].pol_m;
      channel_out_compl[i] = ctl_reg[i].pol_c;
      channel_out_oe[i] = act_reg[i].men | offstate_run_select_reg;
      channel_out_compl_oe[i] = act_reg[i].cen | offstate_run_select_reg;
      if (!main_output_enable_reg) begin
        channel_out_oe[i] = offstate_idle_select_reg;
        channel_out_compl_oe[i] = offstate_idle_select_reg;
        // inactive first, idle after dead time
        if (idle_ready) begin
          channel_out[i] = ctl_reg[i].idle_m;
          channel_out_compl[i] = both_idle_act ? ctl_reg[i].pol_c : ctl_reg[i].idle_c;
        end
      end else if (act_reg[i].men && act_reg[i].cen) begin
        channel_out[i] = (refq_reg[i] & dz) ^ ctl_reg[i].pol_m;
        channel_out_compl[i] = (~refq_reg[i] & dz) ^ ctl_reg[i].pol_c;
      end else if (act_reg[i].men) begin
        channel_out[i] = ref_eff ^ ctl_reg[i].pol_m;
      end else if (act_reg[i].cen) begin
        channel_out_compl[i] = ref_eff ^ ctl_reg[i].pol_c;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data, captured in setup phase
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup) begin
      prdata_reg <= 32'h0;
      case (paddr)
        mpc_pkg::OFF_CTRL: begin
          prdata_reg <= {24'h0, lock_reg, offstate_run_select_reg, offstate_idle_select_reg,
                         outen_s2_reg, auto_output_reenable_reg, break_polarity_reg, break_enable_reg};
        end
        mpc_pkg::OFF_STAT: prdata_reg <= {30'h0, break_flag_reg, commutation_flag_reg};
        mpc_pkg::OFF_IEN: prdata_reg <= {30'h0, break_irq_enable_reg, commutation_irq_enable_reg};
        mpc_pkg::OFF_DT: prdata_reg <= {24'h0, dt_reg};
        default: begin
          for (int k = 0; k < N; k++) begin
            if (paddr == mpc_pkg::OFF_CH0 + mpc_pkg::CH_STRIDE * 8'(k)) begin
              prdata_reg <= ch_rd[k];
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Channel 0 write strobe for the copy check
  logic wr_ch0;
  assign wr_ch0 = g_ch[0].wr_ch;
  AST_COMM_COPY: assert property (comm_ev && !wr_ch0 |=> act_reg[0] == $past(pre_reg[0]))
    else $error("active config not copied on commutation");
  AST_COMM_FLAG: assert property (comm_ev |=> commutation_flag_reg
    && (irq_commutation == commutation_irq_enable_reg))
    else $error("commutation flag not set");
  AST_BRK_MOE: assert property (brk_async |-> !main_output_enable_reg)
    else $error("main enable high during break");
  AST_BRK_FLAG: assert property (brk_s2_reg |=> break_flag_reg && !main_output_enable_reg)
    else $error("break flag or enable wrong");
  AST_BRK_HOLD: assert property (brk_s2_reg && break_flag_reg && wr_stat |=> break_flag_reg)
    else $error("break flag cleared during break");
  AST_AOE: assert property (update_event && auto_output_reenable_reg && !brk_s2_reg && !brk_async
    && !wr_ctrl |=> main_output_enable_reg || brk_async)
    else $error("auto re-enable missed");
  AST_NO_BOTH: assert property (!((channel_out[0] != ctl_reg[0].pol_m)
    && (channel_out_compl[0] != ctl_reg[0].pol_c) && act_reg[0].men && act_reg[0].cen))
    else $error("both outputs active");
  AST_BRK_DELAY: assert property ($fell(main_output_enable_reg) |-> !idle_ready [*3])
    else $error("idle levels before resync delay");
  AST_LOCK_ONCE: assert property (lock_done_reg |=> $stable(lock_reg))
    else $error("lock field changed twice");
  AST_REF_CLEAR: assert property (clr_reg[0] && $past(clr_reg[0]) && !g_ch[0].forced
    && !$past(g_ch[0].forced) && main_output_enable_reg && act_reg[0].men
    |-> channel_out[0] == ctl_reg[0].pol_m)
    else $error("reference not cleared at output");
endmodule

// ==== logic/mpc_pkg.sv ====
// Functional notes
// - Preloaded channel config copied together on commutation
// - Commutation from software bit or trigger rise
// - Commutation sets flag; interrupt when enabled
// - Reset: break disabled, main output enable low
// - Break enable and polarity bits, one write
// - Main output enable resynchronised; readback lags
// - Break level clears main enable without clock
// - Main enable low: idle levels, idle-select enables
// - Break forces inactive complementary levels asynchronously
// - Idle levels after dead time, never both active
// - Break dead time two cycles longer
// - Break sets flag; interrupt when enabled
// - Auto re-enable at update event, else software
// - Break level blocks main enable and flag clear
// - Three lock levels; lock field written once
// - Trigger high clears reference until update event
// - Reference clearing ignored in forced modes
// - Both enabled: main follows reference, complement inverse
package mpc_pkg;
  localparam int NCH = 3;
  localparam int AW = 8;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IEN = 8'h08;
  localparam logic [7:0] OFF_EVT = 8'h0c;
  localparam logic [7:0] OFF_DT = 8'h10;
  localparam logic [7:0] OFF_CH0 = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_BRK_EN = 0;
  localparam int B_BRK_POL = 1;
  localparam int B_AUTO_EN = 2;
  localparam int B_MAIN_EN = 3;
  localparam int B_OFF_IDLE = 4;
  localparam int B_OFF_RUN = 5;
  localparam int B_LOCK = 6;
  localparam int B_COMF = 0;
  localparam int B_BRKF = 1;
  localparam int B_COMM_SW = 0;
  localparam int CH_CTRL_LSB = 5;
  localparam int CH_ACT_LSB = 16;
  // Reset values and codes
  localparam logic [7:0] DT_RST = 8'h00;
  localparam logic [1:0] LOCK_L1 = 2'h1;
  localparam logic [1:0] LOCK_L2 = 2'h2;
  localparam logic [1:0] LOCK_L3 = 2'h3;
  localparam logic [2:0] MODE_FORCE_LO = 3'h4;
  localparam logic [2:0] MODE_FORCE_HI = 3'h5;
  // Channel output configuration, preloaded and active
  typedef struct packed {
    logic cen;
    logic men;
    logic [2:0] mode;
  } mpc_cfg_s;
  // Channel static settings
  typedef struct packed {
    logic idle_c;
    logic idle_m;
    logic pol_c;
    logic pol_m;
    logic rce;
  } mpc_ctl_s;
endpackage

// ==== sim/mpc_stage_model.sv ====
module mpc_stage_model (
  // Command from bench
  input wire logic alarm_req,
  // Gate drive from block
  input wire logic [mpc_pkg::NCH-1:0] drv_m,
  input wire logic [mpc_pkg::NCH-1:0] drv_c,
  // Alarm to block, shoot-through flag to bench
  output logic alarm_pin,
  output logic shoot_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------
  // Protection alarm, active high
  // --------------------------------------------------
  assign alarm_pin = alarm_req;
  // Latch any instant both legs conduct
  // never both active
  initial shoot_seen = 1'b0;
  always @(drv_m or drv_c) if ((drv_m & drv_c) != '0) shoot_seen = 1'b1;
endmodule

// ==== sim/mpc_pwm_out_tb.sv ====
module mpc_pwm_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, upd = 1'b0, trig = 1'b0, etr = 1'b0, alarm = 1'b0, brk, shoot;
  logic [2:0] refs = 3'h0, co, coe, cc, cce;
  logic irq_c, irq_b;
  int n_errors = 0, check_count = 0;
  always #5 pclk = ~pclk;
  // --------------------------------------------------
  // Block and power stage
  // --------------------------------------------------
  mpc_pwm_out u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .update_event(upd), .ref_in(refs), .break_pin(brk), .trigger_input(trig),
    .ext_trigger_filtered(etr), .channel_out(co), .channel_out_oe(coe), .channel_out_compl(cc),
    .channel_out_compl_oe(cce), .irq_commutation(irq_c), .irq_break(irq_b));
  mpc_stage_model u_stage (.alarm_req(alarm), .drv_m(co), .drv_c(cc), .alarm_pin(brk), .shoot_seen(shoot));
  // --------------------------------------------------
  // Reporting
  // --------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(rd & mask, exp);
  endtask
  task automatic pulse_upd();
    upd <= 1'b1;
    cyc(1);
    upd <= 1'b0;
    cyc(4);
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    cyc(20);
    presetn <= 1'b1;
    rchk(mpc_pkg::OFF_CTRL, 32'hffffffff, 32'h0); // break off, enable low
    rchk(mpc_pkg::OFF_STAT, 32'hffffffff, 32'h0); // flags clear
    rchk(8'h40, 32'hffffffff, 32'h0);
    chk1(err, 1'b1);
    $display("test reset done");
    wr(mpc_pkg::OFF_DT, 32'h0);
    wr(mpc_pkg::OFF_IEN, 32'h3);
    wr(mpc_pkg::OFF_CH0, 32'h13e);
    for (int i = 1; i < 3; i++) wr(mpc_pkg::OFF_CH0 + 8'(i * 4), 32'h1e);
    rchk(mpc_pkg::OFF_CH0, 32'h1f0000, 32'h0); // preload not active yet
    wr(mpc_pkg::OFF_EVT, 32'h1); // software commutation
    for (int i = 0; i < 3; i++) rchk(mpc_pkg::OFF_CH0 + 8'(i * 4), 32'h1f0000, 32'h1e0000); // all at once
    rchk(mpc_pkg::OFF_STAT, 32'h3, 32'h1); // flag set
    chk1(irq_c, 1'b1); // interrupt
    wr(mpc_pkg::OFF_STAT, 32'h0);
    rchk(mpc_pkg::OFF_STAT, 32'h3, 32'h0); // clear by zero
    wr(mpc_pkg::OFF_CH0 + 8'h4, 32'h0e);
    trig <= 1'b1;
    cyc(6);
    trig <= 1'b0;
    rchk(mpc_pkg::OFF_CH0 + 8'h4, 32'h1f0000, 32'h0e0000); // trigger rise
    rchk(mpc_pkg::OFF_STAT, 32'h3, 32'h1); // flag again
    wr(mpc_pkg::OFF_STAT, 32'h0);
    $display("test commutation done");
    wr(mpc_pkg::OFF_CTRL, 32'h1f);
    cyc(4);
    rchk(mpc_pkg::OFF_CTRL, 32'hff, 32'h1f); // bits and synced enable after wait
    refs <= 3'h1;
    cyc(5);
    chk1(co[0], 1'b1); // main follows reference
    chk1(cc[0], 1'b0); // complement inverse
    refs <= 3'h0;
    cyc(5);
    chk1(co[0], 1'b0); // main off
    chk1(cc[0], 1'b1); // complement on
    refs <= 3'h1;
    cyc(5);
    alarm <= 1'b1;
    #1;
    chk1(co[0], 1'b0); // inactive at once
    chk1(cc[0], 1'b0); // complement inactive
    chk1(cc[2], 1'b0); // active complement dropped
    cyc(10);
    chk1(co[0], 1'b1); // idle level after dead time
    chk1(coe[0], 1'b1); // idle select keeps enable
    chk1(cce[0], 1'b1); // idle select keeps complement enable
    rchk(mpc_pkg::OFF_STAT, 32'h2, 32'h2); // break flag
    chk1(irq_b, 1'b1); // interrupt
    wr(mpc_pkg::OFF_CTRL, 32'h1f);
    cyc(4);
    rchk(mpc_pkg::OFF_CTRL, 32'h8, 32'h0); // enable refused
    wr(mpc_pkg::OFF_STAT, 32'h0);
    rchk(mpc_pkg::OFF_STAT, 32'h2, 32'h2); // flag stays
    alarm <= 1'b0;
    cyc(5);
    pulse_upd();
    rchk(mpc_pkg::OFF_CTRL, 32'hff, 32'h1f); // auto re-enable
    wr(mpc_pkg::OFF_STAT, 32'h0);
    rchk(mpc_pkg::OFF_STAT, 32'h3, 32'h0); // clear after break
    $display("test break done");
    // trigger arrives already filtered, no prescale
    etr <= 1'b1;
    cyc(6);
    chk1(co[0], 1'b0); // reference cleared
    etr <= 1'b0;
    cyc(6);
    chk1(co[0], 1'b0); // held until update
    pulse_upd();
    chk1(co[0], 1'b1); // released by update
    wr(mpc_pkg::OFF_CH0, 32'h13d);
    wr(mpc_pkg::OFF_EVT, 32'h1);
    refs <= 3'h0;
    etr <= 1'b1;
    cyc(6);
    chk1(co[0], 1'b1); // forced mode unaffected
    etr <= 1'b0;
    $display("test reference clear done");
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    rchk(mpc_pkg::OFF_CTRL, 32'hffffffff, 32'h0); // cleared again by reset
    wr(mpc_pkg::OFF_CTRL, {24'h0, mpc_pkg::LOCK_L1, 6'h01});
    wr(mpc_pkg::OFF_CTRL, {24'h0, mpc_pkg::LOCK_L3, 6'h02});
    rchk(mpc_pkg::OFF_CTRL, 32'hc3, {24'h0, mpc_pkg::LOCK_L1, 6'h01}); // lock once, fields frozen
    chk1(shoot, 1'b0); // never both active
    $display("test lock done");
    tally_and_finish();
  end
endmodule
